// file: design/encoder_interface.sv
// Quadrature encoder interface: decode, position, velocity and events
//
// Contract
// - Velocity capture runs only while position integration is enabled.
// - Swap option exchanges channels A and B before decoding.
// - Signalling select: zero quadrature, else step clock plus direction.
// - Capture select counts channel A edges only or both channels.
// - A leading B increments position; B leading A decrements.
// - Edge pair on one phase without other phase edge flags direction change.
// - Reset select one clears position on each sensed index pulse.
// - Decrement from zero loads the position limit.
// - Reset select zero keeps position in zero to limit, wrapping to zero.
// - Velocity counts selected edges per timer period into running count.
// - Period end copies running count to captured count and clears it.
// - Timer counts down, at zero raises event and reloads.
// - Predivider scales counted edges by two to the divide field.
// - Events have raw status, mask and write-one clear.
// - Edges per line two at capture zero, four at capture one.
// - Separate bits invert channel A, channel B and index.
// - Freeze bit stalls the block while processor is halted.
`default_nettype none
`include "encoder_interface_params.svh"
module encoder_interface
(
  input  wire logic                        clk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        unit0_channel_a_pin_i,
  input  wire logic                        unit0_channel_b_pin_i,
  input  wire logic                        unit0_index_pin_i,
  input  wire logic                        position_enable_i,
  input  wire logic                        velocity_enable_i,
  input  wire logic                        channel_swap_i,
  input  wire logic                        signalling_select_i,
  input  wire logic                        edge_capture_select_i,
  input  wire logic                        count_reset_select_i,
  input  wire encoder_interface_pkg::div_t velocity_predivide_field_i,
  input  wire logic                        channel_a_invert_i,
  input  wire logic                        channel_b_invert_i,
  input  wire logic                        index_invert_i,
  input  wire logic                        freeze_on_debug_halt_i,
  input  wire logic                        debug_halt_i,
  input  wire encoder_interface_pkg::word_t position_limit_i,
  input  wire encoder_interface_pkg::word_t velocity_timer_reload_i,
  input  wire encoder_interface_pkg::evt_t  event_mask_i,
  input  wire encoder_interface_pkg::evt_t  event_clear_i,
  output logic [`POS_WIDTH-1:0]            position_o,
  output logic [`POS_WIDTH-1:0]            running_edge_count_o,
  output logic [`POS_WIDTH-1:0]            captured_edge_count_o,
  output logic [`POS_WIDTH-1:0]            velocity_timer_o,
  output logic                             direction_o,
  output logic [`EVT_COUNT-1:0]            event_raw_o,
  output logic                             irq_o
);
  import encoder_interface_pkg::*;

  state_t st;
  state_t next_st;

  logic a_now;
  logic b_now;
  logic i_now;
  logic a_edge;
  logic b_edge;
  logic step;
  logic up;
  logic vel_step;
  logic running;
  logic [7:0] div_top;
  evt_t set_evt;

  //////////////////////////////////////////////////////////////////////////////
  // Input conditioning
  always_comb
  begin
    a_now = channel_swap_i ? (st.sync_b[1] ^ channel_b_invert_i) : (st.sync_a[1] ^ channel_a_invert_i);
    b_now = channel_swap_i ? (st.sync_a[1] ^ channel_a_invert_i) : (st.sync_b[1] ^ channel_b_invert_i);
    i_now = st.sync_i[1] ^ index_invert_i;
    a_edge = st.primed && (a_now != st.prev_a);
    b_edge = st.primed && (b_now != st.prev_b);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decoder
  always_comb
  begin
    running = position_enable_i && !(freeze_on_debug_halt_i && debug_halt_i);
    if (signalling_select_i)
    begin
      step = a_edge && a_now;
      up   = !b_now;
    end
    else
    begin
      step = edge_capture_select_i ? (a_edge ^ b_edge) : (a_edge && !b_edge);
      up   = a_edge ? (a_now != b_now) : (a_now == b_now);
    end
    div_top  = 8'((`DIV_ONE << velocity_predivide_field_i) - `DIV_ONE);
    vel_step = step && (st.div_cnt == div_top);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    next_st = st;
    set_evt = '0;
    next_st.sync_a = {st.sync_a[0], unit0_channel_a_pin_i};
    next_st.sync_b = {st.sync_b[0], unit0_channel_b_pin_i};
    next_st.sync_i = {st.sync_i[0], unit0_index_pin_i};
    if (!(freeze_on_debug_halt_i && debug_halt_i))
    begin
      next_st.prev_a = a_now;
      next_st.prev_b = b_now;
      next_st.prev_i = i_now;
      next_st.primed = 1'b1;
    end
    if (running)
    begin
      if (!signalling_select_i && a_edge && b_edge)
        set_evt[`EVT_PHASE_ERR] = 1'b1;
      // edge pair on one phase only
      if (!signalling_select_i && (a_edge ^ b_edge))
      begin
        if ((a_edge && st.last == LAST_A && a_now == st.last_level)
            || (b_edge && st.last == LAST_B && b_now == st.last_level))
          set_evt[`EVT_DIR_CHANGE] = 1'b1;
        next_st.last       = a_edge ? LAST_A : LAST_B;
        next_st.last_level = !(a_edge ? a_now : b_now);
      end
      if (step)
      begin
        next_st.dir = up;
        if (up)
          // wrap to zero past the limit
          next_st.pos = (st.pos >= position_limit_i) ? `POS_RESET : st.pos + `ONE_COUNT;
        else
          next_st.pos = (st.pos == `POS_RESET) ? position_limit_i : st.pos - `ONE_COUNT;
      end
      if (i_now && !st.prev_i && st.primed)
      begin
        set_evt[`EVT_INDEX] = 1'b1;
        if (count_reset_select_i)
          next_st.pos = `POS_RESET;
      end
      if (velocity_enable_i)
      begin
        if (step)
          next_st.div_cnt = vel_step ? 8'h00 : st.div_cnt + 8'h01;
        if (st.timer == `ZERO_COUNT)
        begin
          set_evt[`EVT_TIMER] = 1'b1;
          next_st.timer = velocity_timer_reload_i;
          next_st.speed = st.count + (vel_step ? `ONE_COUNT : `ZERO_COUNT);
          next_st.count = `ZERO_COUNT;
        end
        else
        begin
          next_st.timer = st.timer - `ONE_COUNT;
          if (vel_step)
            next_st.count = st.count + `ONE_COUNT;
        end
      end
    end
    // sticky raw, set wins over clear
    next_st.raw = (st.raw & ~event_clear_i) | set_evt;
    next_st.irq = |(next_st.raw & event_mask_i);
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st      <= '0;
      st.last <= LAST_NONE;
    end
    else
      st <= next_st;
  end

  // Outputs straight from flops
  assign position_o            = st.pos;
  assign running_edge_count_o  = st.count;
  assign captured_edge_count_o = st.speed;
  assign velocity_timer_o      = st.timer;
  assign direction_o           = st.dir;
  assign event_raw_o           = st.raw;
  assign irq_o                 = st.irq;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_vel_needs_pos: assert property (!position_enable_i |=> $stable(running_edge_count_o))
    else $error("velocity count moved with position disabled");
  chk_timer_reload: assert property (running && velocity_enable_i && velocity_timer_o == `ZERO_COUNT
    |=> velocity_timer_o == $past(velocity_timer_reload_i) && event_raw_o[`EVT_TIMER])
    else $error("timer did not reload");
  chk_count_clear: assert property (running && velocity_enable_i && velocity_timer_o == `ZERO_COUNT
    |=> running_edge_count_o == `ZERO_COUNT)
    else $error("running count not cleared");
  chk_pos_underflow: assert property (running && step && !up && position_o == `POS_RESET
    && !(i_now && !st.prev_i) |=> position_o == $past(position_limit_i))
    else $error("underflow did not load limit");
  chk_index_clear: assert property (running && count_reset_select_i && i_now && !st.prev_i && st.primed
    |=> position_o == `POS_RESET)
    else $error("index did not clear position");
  chk_phase_err: assert property (running && !signalling_select_i && a_edge && b_edge
    |=> event_raw_o[`EVT_PHASE_ERR])
    else $error("phase error missed");
  chk_pos_inc: assert property (running && step && up && position_o < position_limit_i
    && !(i_now && !st.prev_i) |=> position_o == $past(position_o) + `ONE_COUNT)
    else $error("position did not increment");
  chk_freeze_halt: assert property (freeze_on_debug_halt_i && debug_halt_i
    |=> $stable(position_o) && $stable(velocity_timer_o))
    else $error("state moved during halt");
  chk_irq_mask: assert property (irq_o == |(event_raw_o & $past(event_mask_i)))
    else $error("interrupt does not follow masked status");

  cov_index_reset: cover property (count_reset_select_i ##1 position_o == `POS_RESET);
  cov_period_end: cover property (velocity_enable_i && velocity_timer_o == `ZERO_COUNT);
  cov_dir_change: cover property (set_evt[`EVT_DIR_CHANGE]);
  cov_irq: cover property (irq_o);
endmodule : encoder_interface
`default_nettype wire

// file: design/encoder_interface_params.svh
// Constants for the quadrature encoder interface
`ifndef ENCODER_INTERFACE_PARAMS_SVH
`define ENCODER_INTERFACE_PARAMS_SVH
`define POS_WIDTH      32
`define TIMER_WIDTH    32
`define VELOCITY_PREDIVIDE_FIELD_WIDTH   3
`define POS_RESET      32'h0000_0000
`define TIMER_RESET    32'h0000_0000
`define ZERO_COUNT     32'h0000_0000
`define ONE_COUNT      32'h0000_0001
`define DIV_ONE        8'h01
`define EVT_PHASE_ERR  0
`define EVT_DIR_CHANGE 1
`define EVT_INDEX      2
`define EVT_TIMER      3
`define EVT_COUNT      4
`endif

// file: design/encoder_interface_pkg.sv
// Types for the quadrature encoder interface
`default_nettype none
`include "encoder_interface_params.svh"
package encoder_interface_pkg;
  typedef logic [`POS_WIDTH-1:0]    word_t;
  typedef logic [`VELOCITY_PREDIVIDE_FIELD_WIDTH-1:0] div_t;
  typedef logic [`EVT_COUNT-1:0]    evt_t;

  // Direction memory for change detection
  typedef enum logic [2:0]
  {
    LAST_NONE = 3'b001,
    LAST_A    = 3'b010,
    LAST_B    = 3'b100
  } last_edge_t;

  typedef struct packed
  {
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [1:0] sync_i;
    logic       prev_a;
    logic       prev_b;
    logic       prev_i;
    logic       primed;
    last_edge_t last;
    logic       last_level;
    logic       dir;
    word_t      pos;
    word_t      count;
    word_t      speed;
    word_t      timer;
    logic [7:0] div_cnt;
    evt_t       raw;
    logic       irq;
  } state_t;
endpackage : encoder_interface_pkg
`default_nettype wire

// file: tb/encoder_model.sv
// Incremental encoder model driving phase and index pins
`default_nettype none
module encoder_model
(
  input  wire logic clk_i,
  output var  logic chan_a_o,
  output var  logic chan_b_o,
  output var  logic index_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase = 2'h0;
  initial {chan_a_o, chan_b_o, index_o} = 3'h0;
  task automatic drive(input logic a, input logic b, input logic i);
    @(negedge clk_i);
    {chan_a_o, chan_b_o, index_o} = {a, b, i};
    repeat (4) @(posedge clk_i);
  endtask : drive
  // One step in Gray order, channel a leads going up
  task automatic step(input logic up);
    phase = up ? phase + 2'h1 : phase - 2'h1;
    drive(phase[1] ^ phase[0], phase[1], 1'b0);
  endtask : step
endmodule : encoder_model
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the encoder interface
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import encoder_interface_pkg::*;
  logic  clk_i = 1'b0, sys_rst_i = 1'b1, pos_en = 1'b0, vel_en = 1'b0, swap = 1'b0;
  logic  inv_a = 1'b0, inv_b = 1'b0, inv_i = 1'b0;
  logic  sig_sel = 1'b0, cap_sel = 1'b1, rst_sel = 1'b0, freeze = 1'b0, halt = 1'b0;
  div_t  div = 3'h0;
  word_t limit = 32'h9, reload = 32'h3e8;
  evt_t  mask = 4'h8, clr = 4'h0;
  logic  a, b, idx, dir, irq;
  word_t pos, run_cnt, cap_cnt, timer;
  evt_t  raw;
  int    n_errors = 0, n_tests = 0, cycles = 0;
  encoder_model u_enc (.clk_i(clk_i), .chan_a_o(a), .chan_b_o(b), .index_o(idx));
  encoder_interface u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .unit0_channel_a_pin_i(a),
    .unit0_channel_b_pin_i(b), .unit0_index_pin_i(idx), .position_enable_i(pos_en),
    .velocity_enable_i(vel_en), .channel_swap_i(swap), .signalling_select_i(sig_sel),
    .edge_capture_select_i(cap_sel), .count_reset_select_i(rst_sel), .velocity_predivide_field_i(div),
    .channel_a_invert_i(inv_a), .channel_b_invert_i(inv_b), .index_invert_i(inv_i),
    .freeze_on_debug_halt_i(freeze), .debug_halt_i(halt), .position_limit_i(limit),
    .velocity_timer_reload_i(reload), .event_mask_i(mask), .event_clear_i(clr), .position_o(pos),
    .running_edge_count_o(run_cnt), .captured_edge_count_o(cap_cnt), .velocity_timer_o(timer),
    .direction_o(dir), .event_raw_o(raw), .irq_o(irq));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_errors++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Compare one value, settled after the edge
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    #1;
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Pulse the event clear for one cycle
  task automatic clear_ev();
    @(negedge clk_i) clr = 4'hf;
    @(negedge clk_i) clr = 4'h0;
  endtask : clear_ev
  // Counts and verdict
  task automatic end_sim();
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial
  begin
    repeat (16) @(posedge clk_i);
    @(negedge clk_i) sys_rst_i = 1'b0;
    chk("pos", 32'h0, pos);
    @(negedge clk_i) pos_en = 1'b1;
    repeat (4) @(posedge clk_i);
    repeat (4) u_enc.step(1'b1);
    chk("pos", 32'h4, pos);
    chk("dir", 32'h1, 32'(dir));
    chk("run", 32'h0, run_cnt);
    repeat (5) u_enc.step(1'b0);
    chk("pos", 32'h9, pos);
    chk("dir", 32'h0, 32'(dir));
    chk("dirchg", 32'h1, 32'(raw[1]));
    chk("irq", 32'h0, 32'(irq));
    u_enc.step(1'b1);
    chk("pos", 32'h0, pos);
    clear_ev();
    chk("raw", 32'h0, 32'(raw));
    $display("test up/down done");
    @(negedge clk_i) cap_sel = 1'b0;
    repeat (4) u_enc.step(1'b1);
    chk("pos", 32'h2, pos);
    @(negedge clk_i) cap_sel = 1'b1;
    @(negedge clk_i) swap = 1'b1;
    u_enc.step(1'b1);
    chk("pos", 32'h1, pos);
    u_enc.step(1'b0);
    @(negedge clk_i) swap = 1'b0;
    @(negedge clk_i) rst_sel = 1'b1;
    u_enc.drive(1'b0, 1'b0, 1'b1);
    chk("pos", 32'h0, pos);
    chk("index", 32'h1, 32'(raw[2]));
    u_enc.drive(1'b0, 1'b0, 1'b0);
    @(negedge clk_i) rst_sel = 1'b0;
    u_enc.drive(1'b1, 1'b1, 1'b0);
    chk("phaseerr", 32'h1, 32'(raw[0]));
    chk("pos", 32'h0, pos);
    u_enc.drive(1'b0, 1'b0, 1'b0);
    // Inverting one channel at a time looks like forward motion
    @(negedge clk_i) inv_a = 1'b1;
    repeat (4) @(posedge clk_i);
    chk("pos", 32'h1, pos);
    @(negedge clk_i) inv_b = 1'b1;
    repeat (4) @(posedge clk_i);
    chk("pos", 32'h2, pos);
    @(negedge clk_i) inv_a = 1'b0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i) inv_b = 1'b0;
    repeat (4) @(posedge clk_i);
    chk("pos", 32'h4, pos);
    // Inverted idle index reads as a pulse and clears position
    @(negedge clk_i) {rst_sel, inv_i} = 2'h3;
    repeat (4) @(posedge clk_i);
    chk("pos", 32'h0, pos);
    @(negedge clk_i) {rst_sel, inv_i} = 2'h0;
    repeat (4) @(posedge clk_i);
    $display("test modes done");
    @(negedge clk_i) {freeze, halt} = 2'h3;
    u_enc.step(1'b1);
    chk("pos", 32'h0, pos);
    u_enc.step(1'b0);
    @(negedge clk_i) {freeze, halt, sig_sel} = 3'h1;
    u_enc.drive(1'b1, 1'b0, 1'b0);
    chk("pos", 32'h1, pos);
    u_enc.drive(1'b0, 1'b1, 1'b0);
    u_enc.drive(1'b1, 1'b1, 1'b0);
    chk("pos", 32'h0, pos);
    u_enc.drive(1'b0, 1'b0, 1'b0);
    @(negedge clk_i) {sig_sel, vel_en} = 2'h1;
    repeat (4) @(posedge clk_i);
    clear_ev();
    repeat (8) u_enc.step(1'b1);
    chk("run", 32'h8, run_cnt);
    @(negedge clk_i) div = 3'h1;
    repeat (4) u_enc.step(1'b1);
    chk("run", 32'ha, run_cnt);
    for (int k = 0; k < 1100 && raw[3] !== 1'b1; k++)
      @(negedge clk_i);
    chk("speed", 32'ha, cap_cnt);
    chk("run", 32'h0, run_cnt);
    chk("timer", reload, timer);
    chk("irq", 32'h1, 32'(irq));
    $display("test velocity done");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
